// [logic/uhc_cmd_reg.sv]
// host command register: threshold, light reset, async advance doorbell
`timescale 1ns/10ps
// How it works
// RULE1 - threshold code 20h means 32 microframes and 40h means 64 microframes.
// RULE2 - threshold sits in bits 23..16, resets to 08h, codes 01h..10h are powers of two.
// RULE3 - software changes the threshold only while the halted flag reads one.
// RULE4 - if light reset is not built, bit 7 always reads zero.
// RULE5 - bit 7 reads one while light reset runs and zero once it is done.
// RULE6 - light reset clears controller state but not ports or companion routing.
// RULE7 - software writes one to bit 6 to ring the async advance doorbell.
// RULE8 - once cached async state is evicted the async advance flag is set.
// RULE9 - with the flag set and enabled, the interrupt rises at the next threshold boundary.
// RULE10 - the doorbell clears itself after the flag is set.
// RULE11 - software never rings the doorbell while the async schedule is inactive.
// RULE12 - writing zero to the doorbell does nothing; reserved bits read zero.
module uhc_cmd_reg #(
  parameter bit LRST_IMPL = 1'b1
) (
  // clock and reset
  input wire logic clock_in,
  input wire logic sys_rst_in,
  // register access
  input wire logic [7:0] reg_addr_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [31:0] reg_wdata_in,
  output logic [31:0] reg_rdata_out,
  // status and schedule coupling
  input wire logic [31:0] host_status_register_in,
  input wire logic async_advance_interrupt_enable_in,
  input wire logic microframe_tick_in,
  input wire logic async_evicted_in,
  input wire logic async_status_clear_in,
  output logic async_advance_status_flag_out,
  output logic evict_request_out,
  output logic light_reset_out,
  output logic [6:0] threshold_microframes_out,
  output logic irq_out
);
  import uhc_pkg::*;

  // register state and its next value
  uhc_state_s s_q;
  uhc_state_s s_d;

  // decoded register accesses
  logic cmd_wr;
  logic cmd_rd;

  // qualified write requests
  logic itc_write;
  logic lrst_start;
  logic door_ring;

  // schedule and status coupling
  logic halted;
  logic evict_done;
  logic lrst_last;

  // threshold interval tracking
  logic [7:0] limit;
  logic [7:0] mf_next;
  logic mf_wrap;
  logic irq_allowed;

  // address decode; other offsets are not this block's
  assign cmd_wr = reg_wr_in && (reg_addr_in == CMD_OFFSET);
  assign cmd_rd = reg_rd_in && (reg_addr_in == CMD_OFFSET);

  // halted flag from the status register
  assign halted = host_status_register_in[HALT_BIT];

  // threshold moves only while halted and outside a light reset
  assign itc_write = cmd_wr && halted && !s_q.lrst; // [RULE3]

  // light reset starts only when built and not already running
  assign lrst_start = cmd_wr && LRST_IMPL && reg_wdata_in[LRST_BIT] && !s_q.lrst; // [RULE5]

  // a zero in the doorbell position is not a request
  assign door_ring = cmd_wr && reg_wdata_in[DOOR_BIT]; // [RULE12]

  // schedule engine has answered the pending doorbell
  assign evict_done = (s_q.door == UHC_WAIT) && async_evicted_in; // [RULE8]

  // last clock of the light reset sequence
  assign lrst_last = (s_q.lrst_cnt == LRST_CYCLES);

  // microframe position within the current threshold interval
  assign mf_next = s_q.mf_cnt + 8'h01;

  // boundary is the tick that completes the interval
  assign mf_wrap = microframe_tick_in && (mf_next >= limit);

  // interrupt may only stand while both flag and enable are set
  assign irq_allowed = s_q.aas && async_advance_interrupt_enable_in; // [RULE9]

  // code values equal the microframe count, so the decode only filters
  always_comb begin
    unique case (s_q.interrupt_threshold_field)
      ITC_1, ITC_2, ITC_4, ITC_8, ITC_16: begin
        limit = s_q.interrupt_threshold_field; // [RULE2]
      end
      ITC_32, ITC_64: begin
        limit = s_q.interrupt_threshold_field; // [RULE1]
      end
      default: begin
        // reserved and undefined codes run at the reset interval
        limit = ITC_8;
      end
    endcase
  end

  // single next-state process for the whole register
  always_comb begin
    // hold everything unless a rule below moves it
    s_d = s_q;

    // threshold write, refused while running or during light reset
    if (itc_write) begin
      s_d.interrupt_threshold_field = reg_wdata_in[ITC_MSB:ITC_LSB]; // [RULE2] [RULE3]
    end

    if (s_q.lrst) begin
      // light reset sequencing
      if (lrst_last) begin
        s_d.lrst = 1'b0; // [RULE5]
        s_d.lrst_cnt = 4'h0;
      end else begin
        s_d.lrst_cnt = s_q.lrst_cnt + 4'h1;
      end

      // internal state only; ports are outside this block
      // a pending doorbell is dropped, software rings again after re-init
      s_d.interrupt_threshold_field = ITC_RESET; // [RULE6]
      s_d.door = UHC_IDLE; // [RULE6]
      s_d.aas = 1'b0; // [RULE6]
      s_d.mf_cnt = 8'h00;
      s_d.irq = 1'b0;
    end else if (lrst_start) begin
      s_d.lrst = 1'b1; // [RULE5]
      s_d.lrst_cnt = 4'h0;
    end else begin
      // doorbell handshake with the schedule engine
      unique case (s_q.door)
        UHC_IDLE: begin
          // writing zero leaves the doorbell alone
          if (door_ring) begin
            s_d.door = UHC_WAIT; // [RULE7] [RULE12]
          end
        end
        UHC_WAIT: begin
          if (evict_done) begin
            s_d.door = UHC_DONE; // [RULE8]
          end
        end
        UHC_DONE: begin
          // flag is set by now, so the doorbell drops
          s_d.door = UHC_IDLE; // [RULE10]
        end
        default: begin
          // only the unused code lands here
          s_d.door = UHC_IDLE;
        end
      endcase

      // async advance flag: a set in the same clock as a clear wins
      if (evict_done) begin
        s_d.aas = 1'b1; // [RULE8]
      end else if (async_status_clear_in) begin
        s_d.aas = 1'b0;
      end

      // threshold boundary counter
      if (microframe_tick_in) begin
        if (mf_wrap) begin
          s_d.mf_cnt = 8'h00;
          s_d.irq = irq_allowed; // [RULE9]
        end else begin
          s_d.mf_cnt = mf_next;
        end
      end

      // interrupt is a level that drops as soon as the flag or its enable clears
      if (!irq_allowed) begin
        s_d.irq = 1'b0;
      end
    end

    // read data; reserved bits stay zero
    s_d.rdata = 32'h0000_0000; // [RULE12]
    // only the command register returns data, other offsets read zero
    if (cmd_rd) begin
      s_d.rdata[ITC_MSB:ITC_LSB] = s_q.interrupt_threshold_field;
      s_d.rdata[LRST_BIT] = LRST_IMPL ? s_q.lrst : 1'b0; // [RULE4] [RULE5]
      s_d.rdata[DOOR_BIT] = (s_q.door != UHC_IDLE); // [RULE10]
    end
  end

  // asynchronous reset loads constants only
  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      s_q <= '{
        interrupt_threshold_field: ITC_RESET, // [RULE2]
        lrst: 1'b0,
        lrst_cnt: 4'h0,
        door: UHC_IDLE,
        aas: 1'b0,
        mf_cnt: 8'h00,
        irq: 1'b0,
        rdata: 32'h0000_0000
      };
    end else begin
      s_q <= s_d;
    end
  end

  // outputs from the state register; evict request and threshold pass through a decode
  assign reg_rdata_out = s_q.rdata;
  assign async_advance_status_flag_out = s_q.aas; // [RULE8]
  // schedule engine is asked to evict while the doorbell waits
  assign evict_request_out = (s_q.door == UHC_WAIT);
  assign light_reset_out = s_q.lrst; // [RULE5]
  assign threshold_microframes_out = limit[6:0]; // [RULE1] [RULE2]
  assign irq_out = s_q.irq; // [RULE9]
endmodule : uhc_cmd_reg

// [logic/uhc_pkg.sv]
// constants for the host command register part
package uhc_pkg;
  localparam logic [7:0] CMD_OFFSET = 8'h20;
  localparam int ITC_LSB = 16;
  localparam int ITC_MSB = 23;
  localparam int LRST_BIT = 7;
  localparam int DOOR_BIT = 6;
  localparam int HALT_BIT = 12;
  localparam int AAS_BIT = 5;
  localparam logic [7:0] ITC_RESET = 8'h08;
  localparam logic [7:0] ITC_RSVD = 8'h00;
  localparam logic [7:0] ITC_1 = 8'h01;
  localparam logic [7:0] ITC_2 = 8'h02;
  localparam logic [7:0] ITC_4 = 8'h04;
  localparam logic [7:0] ITC_8 = 8'h08;
  localparam logic [7:0] ITC_16 = 8'h10;
  localparam logic [7:0] ITC_32 = 8'h20;
  localparam logic [7:0] ITC_64 = 8'h40;
  // last value of the light reset counter; the light reset lasts one clock longer than this
  localparam logic [3:0] LRST_CYCLES = 4'h8;
  typedef enum logic [1:0] {
    UHC_IDLE = 2'b00,
    UHC_WAIT = 2'b01,
    UHC_DONE = 2'b10
  } uhc_door_e;
  typedef struct packed {
    logic [7:0] interrupt_threshold_field;
    logic lrst;
    logic [3:0] lrst_cnt;
    uhc_door_e door;
    logic aas;
    logic [7:0] mf_cnt;
    logic irq;
    logic [31:0] rdata;
  } uhc_state_s;
endpackage : uhc_pkg

// [tb/tb_uhc_cmd_reg.sv]
// bench for the host command register part
`timescale 1ns/10ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin n_mismatch++; \
  $display("[ERR] %0t got %h exp %h", $time, a, b); end end
module tb_uhc_cmd_reg import uhc_pkg::*;;
  logic clock_in = 0, sys_rst_in = 1, reg_wr_in = 0, reg_rd_in = 0, async_status_clear_in = 0;
  logic async_advance_interrupt_enable_in = 0, async_evicted_in, microframe_tick_in;
  logic async_advance_status_flag_out, evict_request_out, light_reset_out, irq_out;
  logic [7:0] reg_addr_in = CMD_OFFSET;
  logic [31:0] reg_wdata_in = 0, host_status_register_in = 0, reg_rdata_out, q, rdata_bare;
  logic [6:0] threshold_microframes_out;
  logic [3:0] dly = 4'h1;
  logic [7:0] codes [7] = '{ITC_2, ITC_4, ITC_8, ITC_16, ITC_32, ITC_64, ITC_1};
  int n_mismatch = 0, comparisons = 0;
  always #20 clock_in = ~clock_in;
  uhc_cmd_reg uhc_cmd_reg_inst (.*);
  uhc_sched_model uhc_sched_model_inst (.clock_in, .sys_rst_in, .evict_request_in(evict_request_out),
    .delay_in(dly), .async_evicted_out(async_evicted_in), .microframe_tick_out(microframe_tick_in));
  uhc_cmd_reg #(.LRST_IMPL(1'b0)) uhc_cmd_reg_bare_inst (.clock_in, .sys_rst_in,
    .reg_addr_in, .reg_wr_in, .reg_rd_in, .reg_wdata_in, .reg_rdata_out(rdata_bare),
    .host_status_register_in, .async_advance_interrupt_enable_in, .microframe_tick_in,
    .async_evicted_in, .async_status_clear_in, .async_advance_status_flag_out(),
    .evict_request_out(), .light_reset_out(), .threshold_microframes_out(), .irq_out());
  task automatic report_and_stop;
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : report_and_stop
  task automatic wr32(input logic [31:0] d);
    @(negedge clock_in) {reg_wdata_in, reg_wr_in} = {d, 1'b1};
    @(negedge clock_in) reg_wr_in = 0;
  endtask : wr32
  task automatic rd32;
    @(negedge clock_in) reg_rd_in = 1;
    @(negedge clock_in) {q, reg_rd_in} = {reg_rdata_out, 1'b0};
  endtask : rd32
  task automatic wt(ref logic s, input logic v);
    for (int k = 0; k < 60; k++) begin
      if (s === v) return;
      @(negedge clock_in);
    end
    $display("[ERR] %0t got %h exp %h", $time, s, v);
    n_mismatch++;
    report_and_stop();
  endtask : wt
  initial begin
    repeat (10) @(negedge clock_in);
    sys_rst_in = 0;
    rd32(); `CHK(q, {8'h00, ITC_RESET, 16'h0000})
    wr32({8'h00, ITC_32, 16'h0000}); rd32(); `CHK(q[23:16], ITC_RESET)
    host_status_register_in[HALT_BIT] = 1;
    foreach (codes[i]) begin
      wr32({8'hFF, codes[i], 16'hFF00}); rd32(); `CHK(q, {8'h00, codes[i], 16'h0000})
      `CHK({1'b0, threshold_microframes_out}, codes[i])
    end
    `CHK(evict_request_out, 1'b0)
    async_advance_interrupt_enable_in = 1;
    wr32(32'h0001_0040);
    wt(async_advance_status_flag_out, 1); rd32(); `CHK(q[6], 1'b0)
    wt(irq_out, 1); `CHK(irq_out, 1'b1)
    @(negedge clock_in) async_status_clear_in = 1;
    @(negedge clock_in) async_status_clear_in = 0;
    wt(irq_out, 0); `CHK(async_advance_status_flag_out, 1'b0)
    dly = 4'h9;
    host_status_register_in[HALT_BIT] = 0;
    wr32(32'h0000_0040); rd32(); `CHK(q[6], 1'b1)
    wt(async_advance_status_flag_out, 1);
    wr32(32'h0000_0080); rd32(); `CHK(q[7], 1'b1)
    `CHK(rdata_bare[7], 1'b0)
    wt(light_reset_out, 0); rd32(); `CHK(q, {8'h00, ITC_RESET, 16'h0000})
    `CHK(async_advance_status_flag_out, 1'b0)
    report_and_stop();
  end
endmodule : tb_uhc_cmd_reg

// [tb/uhc_cmd_reg_properties.sv]
// assertions for the host command register part
`timescale 1ns/10ps
module uhc_cmd_reg_properties import uhc_pkg::*; (
  input wire logic clock_in, sys_rst_in, reg_wr_in, reg_rd_in, async_evicted_in,
  input wire logic microframe_tick_in, async_advance_status_flag_out, evict_request_out,
  input wire logic light_reset_out, irq_out,
  input wire logic [7:0] reg_addr_in,
  input wire logic [31:0] reg_wdata_in, reg_rdata_out,
  input wire logic [6:0] threshold_microframes_out
);
  default clocking @(posedge clock_in); endclocking
  default disable iff (sys_rst_in);
  logic rd_q;
  always_ff @(posedge clock_in) rd_q <= reg_rd_in && reg_addr_in == CMD_OFFSET;
  a_door_evict: assert property (reg_wr_in && reg_addr_in == CMD_OFFSET &&
    reg_wdata_in[DOOR_BIT] && !light_reset_out |=> evict_request_out) else $error("no evict");
  a_flag_set: assert property (evict_request_out && async_evicted_in
    |=> async_advance_status_flag_out) else $error("flag late");
  a_door_clear: assert property ($rose(async_advance_status_flag_out)
    |-> ##[0:2] !evict_request_out) else $error("door stuck");
  a_irq_tick: assert property ($rose(irq_out)
    |-> $past(microframe_tick_in) || $past(microframe_tick_in, 2)) else $error("irq early");
  a_thr_match: assert property (rd_q
    |-> reg_rdata_out[23:16] == threshold_microframes_out) else $error("thr");
  a_rsvd_zero: assert property (rd_q
    |-> reg_rdata_out[31:24] == 8'h00 && reg_rdata_out[15:8] == 8'h00) else $error("rsvd");
  a_lrst_len: assert property ($rose(light_reset_out)
    |-> light_reset_out[*8] ##[0:2] !light_reset_out) else $error("lrst len");
  a_lrst_clear: assert property ($fell(light_reset_out)
    |-> !async_advance_status_flag_out && threshold_microframes_out == 7'h08) else $error("lrst");
  c_irq: cover property (irq_out);
  c_flag: cover property (async_advance_status_flag_out);
  c_lrst: cover property ($fell(light_reset_out));
endmodule : uhc_cmd_reg_properties
bind uhc_cmd_reg uhc_cmd_reg_properties uhc_cmd_reg_properties_inst (.*);

// [tb/uhc_sched_model.sv]
// schedule engine model: eviction answer after a delay, microframe ticks
`timescale 1ns/10ps
module uhc_sched_model (
  input wire logic clock_in, sys_rst_in, evict_request_in,
  input wire logic [3:0] delay_in,
  output logic async_evicted_out, microframe_tick_out
);
  logic [3:0] wait_q;
  logic [1:0] mf_q;
  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) {wait_q, mf_q} <= 6'h00;
    else {wait_q, mf_q} <= {evict_request_in ? wait_q + 4'h1 : 4'h0, mf_q + 2'h1};
  end
  assign microframe_tick_out = mf_q == 2'h3;
  assign async_evicted_out = evict_request_in && wait_q == delay_in;
endmodule : uhc_sched_model
